/* tb/ctm_core_asserts.sv */
// Concurrent checks on the ports of the test and transfer core
`timescale 1ns/1ps
module ctm_core_chk
    import ctm_pkg::*;
(
    input wire logic          clk,       // System clock
    input wire logic          rst,       // Asynchronous reset, active high
    input wire logic [7:0]    mem_rdata, // Read data from memory
    input ctm_pkg::ctm_bus_s  bus,       // Memory request
    input ctm_pkg::ctm_regs_s regs       // Visible registers
);
    logic        idle;   // No bus access this cycle
    logic [15:0] hx;     // Index pair
    logic [1:0]  wd_nz;  // Sign and zero of the write data
    // Helpers stay combinational so the properties remain short
    assign idle  = !bus.rd && !bus.wr;
    assign hx    = {regs.h, regs.x};
    assign wd_nz = {bus.wdata[7], bus.wdata == 8'h00};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Only overflow, negative and zero may ever move in this block
    flags_fixed_a: assert property ($stable(regs.flags & 8'h79))
        else $error("untouched flag changed");
    nz_excl_a: assert property (!(regs.flags[CTM_FLAG_N] && regs.flags[CTM_FLAG_Z]))
        else $error("negative and zero both set");
    flag_cause_a: assert property ($changed(regs.flags) |-> !$past(idle))
        else $error("flags moved after an idle cycle");
    // The idle cycle belongs to the stack transfers only
    idle_fetch_a: assert property (idle |=> bus.rd)
        else $error("idle cycle not followed by a fetch");
    stack_pair_a: assert property (idle |=> regs.sp == hx - 16'h0001)
        else $error("stack pointer and index pair out of step");
    sp_cause_a: assert property ($changed(regs.sp) |-> $past(idle))
        else $error("stack pointer moved without an idle cycle");
    // Moves write once, then fetch; the byte written was read one or two cycles before
    write_fetch_a: assert property (bus.wr |=> bus.rd && !bus.wr)
        else $error("write not followed by a fetch");
    move_data_a: assert property (bus.wr |->
        bus.wdata == $past(mem_rdata) || bus.wdata == $past(mem_rdata, 2))
        else $error("written byte was never read");
    move_flags_a: assert property (bus.wr |=>
        {regs.flags[CTM_FLAG_N], regs.flags[CTM_FLAG_Z]} == $past(wd_nz) &&
        !regs.flags[CTM_FLAG_V])
        else $error("flags do not follow the moved byte");
endmodule
bind ctm_core ctm_core_chk chk_i (.clk(clk), .rst(rst), .mem_rdata(mem_rdata), .bus(bus),
    .regs(regs));

/* tb/ctm_mem_model.sv */
// Zero-wait program and data memory that faces the test and transfer core
`timescale 1ns/1ps
module ctm_mem_model
    import ctm_pkg::*;
(
    input wire logic          clk,       // System clock
    input ctm_pkg::ctm_bus_s  bus,       // Request from the core
    output logic [7:0]        mem_rdata  // Read data in the request cycle
);
    logic [7:0] mem [0:65535];   // Whole address space, loaded by the bench
    logic [7:0] last_r = 8'h00;  // Last byte handed out
    // Outside a read the line shows the inverse of the last byte, so a core
    // that samples at the wrong time cannot see a plausible value
    assign mem_rdata = bus.rd ? mem[bus.addr] : ~last_r;
    // Writes land at the edge that ends the write cycle
    always @(posedge clk) begin
        if (bus.wr) begin
            mem[bus.addr] <= bus.wdata;
        end
        if (bus.rd) begin
            last_r <= mem[bus.addr];
        end
    end
endmodule

/* tb/tb_cpu_test_transfer_and_operand_modes.sv */
// Self-checking bench for the test and transfer core
`timescale 1ns/1ps
module tb_cpu_test_transfer_and_operand_modes;
    import ctm_pkg::*;
    typedef struct packed {
        logic [63:0] prog;  // Bytes from address 0000, first byte leftmost
        logic [3:0]  cyc;   // Edges after reset release before sampling
        logic [2:0]  sel;   // What is sampled
        logic [15:0] adr;   // Address of a memory sample
        logic [15:0] exp;   // Expected value
    } ctm_row_s;
    logic        clk;
    logic        rst;
    logic [7:0]  mem_rdata;
    ctm_bus_s    bus;
    ctm_regs_s   regs;
    ctm_row_s    rows [20];
    logic [15:0] seen;
    int          errors;
    int          samples_checked;

    ctm_core dut (.clk(clk), .rst(rst), .mem_rdata(mem_rdata), .bus(bus), .regs(regs));
    ctm_mem_model mem_i (.clk(clk), .bus(bus), .mem_rdata(mem_rdata));

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Background byte of every address, chosen so that neighbours differ
    function automatic logic [15:0] pw(input logic [15:0] a);
        return {8'h00, (a[7:0] + a[15:8]) ^ 8'h80};
    endfunction

    task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Reset, refill memory, place the program and release at a falling edge
    task automatic load(input logic [63:0] prog);
        rst = 1'b1;
        for (int i = 0; i < 65536; i++) mem_i.mem[i] = 8'(pw(16'(i)));
        for (int i = 0; i < 8; i++) mem_i.mem[i] = prog[63 - 8 * i -: 8];
        @(negedge clk);
        rst = 1'b0;
    endtask

    task automatic reset_check();
        check("bus in reset", 64'(bus), 64'({16'h0000, 1'b1, 1'b0, 8'h00}));
        check("regs in reset", 64'(regs),
              {CTM_PC_RESET, CTM_SP_RESET, 24'h00_0000, CTM_FLAGS_RESET});
    endtask

    // Stop a hung run well past the expected run of about 130 cycles
    initial begin
        #100_000;
        errors++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        rst = 1'b1;
        errors = 0;
        samples_checked = 0;
        // Samples: 0 acc, 1 index pair, 2 memory, 3 flags, 4 bus address, 5 stack, 6 index low
        rows = '{
            '{64'hC612_3400_0000_0000, 4'h4, 3'h0, 16'h0000, pw(16'h1234)},
            '{64'h95D6_1234_0000_0000, 4'h6, 3'h0, 16'h0000, pw(16'h1334)},
            '{64'h95E6_F000_0000_0000, 4'h5, 3'h0, 16'h0000, pw(16'h01F0)},
            '{64'h9EE6_F000_0000_0000, 4'h4, 3'h0, 16'h0000, pw(16'h01EF)},
            '{64'h9ED6_1234_0000_0000, 4'h5, 3'h0, 16'h0000, pw(16'h1333)},
            '{64'h9571_0500_0000_0000, 4'h5, 3'h1, 16'h0000, 16'h0101},
            '{64'h9561_1005_0000_0000, 4'h6, 3'h1, 16'h0000, 16'h0101},
            '{64'h955E_4000_0000_0000, 4'h6, 3'h2, 16'h0100, pw(16'h0040)},
            '{64'h957E_4000_0000_0000, 4'h6, 3'h2, 16'h0040, pw(16'h0100)},
            '{64'h6E77_4000_0000_0000, 4'h4, 3'h2, 16'h0040, 16'h0077},
            '{64'hC612_344D_0000_0000, 4'h5, 3'h3, 16'h0000, 16'h0004},
            '{64'h5D00_0000_0000_0000, 4'h1, 3'h3, 16'h0000, 16'h0002},
            '{64'h3D80_0000_0000_0000, 4'h3, 3'h3, 16'h0000, 16'h0002},
            '{64'hC612_3497_0000_0000, 4'h5, 3'h6, 16'h0000, pw(16'h1234)},
            '{64'h8500_0000_0000_0000, 4'h1, 3'h0, 16'h0000, 16'h0068},
            '{64'hC612_349F_0000_0000, 4'h5, 3'h0, 16'h0000, 16'h0000},
            '{64'h9500_0000_0000_0000, 4'h2, 3'h1, 16'h0000, 16'h0100},
            '{64'h9571_0594_0000_0000, 4'h7, 3'h5, 16'h0000, 16'h0100},
            '{64'h3106_FE00_0000_0000, 4'h4, 3'h4, 16'h0000, 16'h0001},
            '{64'h3106_0400_0000_0100, 4'h4, 3'h4, 16'h0000, 16'h0003}};
        repeat (12) @(negedge clk);
        reset_check();
        $display("reset test done");
        foreach (rows[k]) begin
            load(rows[k].prog);
            repeat (rows[k].cyc) @(negedge clk);
            case (rows[k].sel)
                3'h0: seen = {8'h00, regs.a};
                3'h1: seen = {regs.h, regs.x};
                3'h2: seen = {8'h00, mem_i.mem[rows[k].adr]};
                3'h3: seen = {8'h00, regs.flags & 8'h86};
                3'h4: seen = bus.addr;
                3'h5: seen = regs.sp;
                default: seen = {8'h00, regs.x};
            endcase
            check("row sample", 64'(seen), 64'(rows[k].exp));
            $display("row %0d done", k);
        end
        // A dropped prefix consumes two bytes and fetches the third
        load(64'h9E00_0000_0000_0000);
        repeat (2) @(negedge clk);
        check("fetch after dropped prefix", 64'(bus.addr), 64'h0000_0000_0000_0002);
        $display("dropped prefix test done");
        // Reset in the middle of an extended load, then a clean rerun
        load(64'hC612_3400_0000_0000);
        repeat (2) @(negedge clk);
        rst = 1'b1;
        #1;
        reset_check();
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check("acc after rerun", 64'(regs.a), 64'(pw(16'h1234)));
        $display("mid-run reset test done");
        conclude();
    end
endmodule

/* verilog/ctm_core.sv */
// Sequencer and datapath for zero test, register transfers and operand modes
`timescale 1ns/1ps
module ctm_core
    import ctm_pkg::*;
(
    input  wire logic        clk,       // System clock, 100 MHz
    input  wire logic        rst,       // Asynchronous reset, active high
    input  wire logic [7:0]  mem_rdata, // Read data, valid in the cycle of the request
    output ctm_pkg::ctm_bus_s  bus,     // Memory request, registered
    output ctm_pkg::ctm_regs_s regs     // Programmer-visible registers
);
    import ctm_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ctm_state_e  state_r, state_nxt;
    ctm_regs_s   regs_r, regs_nxt;
    ctm_bus_s    bus_r, bus_nxt;
    logic [7:0]  op_r, op_nxt;
    logic        pre_r, pre_nxt;
    logic [15:0] ea_r, ea_nxt;
    logic [7:0]  hi_r, hi_nxt;
    logic [7:0]  dat_r, dat_nxt;

    // Flags for a tested or loaded byte: overflow cleared, negative and zero from the byte, others kept
    function automatic logic [7:0] nz_flags(input logic [7:0] c, input logic [7:0] v);
        logic [7:0] f;
        f = c;
        f[CTM_FLAG_V] = 1'b0;
        f[CTM_FLAG_N] = v[7];
        f[CTM_FLAG_Z] = (v == CTM_BYTE_ZERO);
        return f;
    endfunction

    // True for opcodes whose operand sits at the bare index pair
    function automatic logic no_offset(input logic [7:0] o);
        return (o == CTM_OP_ZTEST_BARE) || (o == CTM_OP_LOAD_BARE) ||
               (o == CTM_OP_CBEQ_IXP) || (o == CTM_OP_MOV_IXPD);
    endfunction

    // ------------------------------------------------------------------
    // Next-state and datapath
    // ------------------------------------------------------------------
    // One combinational block keeps sequencing and register updates in step;
    // the bus request is derived last from where the sequencer goes next.
    always_comb begin
        logic [15:0] hx;
        logic [15:0] base;
        hx        = {regs_r.h, regs_r.x};
        base      = pre_r ? regs_r.sp : hx;
        state_nxt = state_r;
        regs_nxt  = regs_r;
        op_nxt    = op_r;
        pre_nxt   = pre_r;
        ea_nxt    = ea_r;
        hi_nxt    = hi_r;
        dat_nxt   = dat_r;
        unique case (state_r)
            CTM_ST_OP: begin
                regs_nxt.pc = regs_r.pc + CTM_ONE16;
                op_nxt      = mem_rdata;
                state_nxt   = CTM_ST_B1;
                if (mem_rdata == CTM_OP_PREFIX && !pre_r) begin
                    pre_nxt   = 1'b1;
                    state_nxt = CTM_ST_OP;
                end else if (!pre_r && no_offset(mem_rdata)) begin
                    ea_nxt    = hx;
                    state_nxt = CTM_ST_RD;
                end else if (!pre_r) begin
                    unique case (mem_rdata)
                        CTM_OP_ZTEST_ACC: begin
                            regs_nxt.flags = nz_flags(regs_r.flags, regs_r.a);
                            state_nxt      = CTM_ST_OP;
                        end
                        CTM_OP_ZTEST_IDX: begin
                            regs_nxt.flags = nz_flags(regs_r.flags, regs_r.x);
                            state_nxt      = CTM_ST_OP;
                        end
                        CTM_OP_ACC_TO_IDX: begin
                            regs_nxt.x = regs_r.a;
                            state_nxt  = CTM_ST_OP;
                        end
                        CTM_OP_IDX_TO_ACC: begin
                            regs_nxt.a = regs_r.x;
                            state_nxt  = CTM_ST_OP;
                        end
                        CTM_OP_FLAGS_TO_ACC: begin
                            regs_nxt.a = regs_r.flags;
                            state_nxt  = CTM_ST_OP;
                        end
                        CTM_OP_STACK_TO_IDX, CTM_OP_IDX_TO_STACK: state_nxt = CTM_ST_EXE;
                        CTM_OP_ZTEST_DIR, CTM_OP_ZTEST_OFS, CTM_OP_LOAD_FULL,
                        CTM_OP_LOAD_LONG, CTM_OP_LOAD_SHORT, CTM_OP_CBEQ_DIR,
                        CTM_OP_CBEQ_OFSP, CTM_OP_MOV_DIXP,
                        CTM_OP_MOV_IMMDIR: state_nxt = CTM_ST_B1;
                        default: state_nxt = CTM_ST_OP;            // Unsupported: one-cycle no-op
                    endcase
                end else if (mem_rdata != CTM_OP_ZTEST_OFS && mem_rdata != CTM_OP_LOAD_SHORT &&
                             mem_rdata != CTM_OP_LOAD_LONG) begin
                    pre_nxt   = 1'b0;                              // Unknown prefixed opcode
                    state_nxt = CTM_ST_OP;
                end
            end
            CTM_ST_B1: begin
                regs_nxt.pc = regs_r.pc + CTM_ONE16;
                state_nxt   = CTM_ST_RD;
                unique case (op_r)
                    CTM_OP_LOAD_FULL, CTM_OP_LOAD_LONG: begin
                        hi_nxt    = mem_rdata;
                        state_nxt = CTM_ST_B2;
                    end
                    CTM_OP_MOV_IMMDIR: begin
                        dat_nxt   = mem_rdata;
                        state_nxt = CTM_ST_B2;
                    end
                    CTM_OP_ZTEST_OFS, CTM_OP_LOAD_SHORT, CTM_OP_CBEQ_OFSP:
                        ea_nxt = base + {CTM_BYTE_ZERO, mem_rdata};
                    default:
                        ea_nxt = {CTM_BYTE_ZERO, mem_rdata};
                endcase
            end
            CTM_ST_B2: begin
                regs_nxt.pc = regs_r.pc + CTM_ONE16;
                unique case (op_r)
                    CTM_OP_LOAD_FULL: begin
                        ea_nxt    = {hi_r, mem_rdata};
                        state_nxt = CTM_ST_RD;
                    end
                    CTM_OP_LOAD_LONG: begin
                        ea_nxt    = base + {hi_r, mem_rdata};
                        state_nxt = CTM_ST_RD;
                    end
                    default: begin
                        ea_nxt    = {CTM_BYTE_ZERO, mem_rdata};
                        state_nxt = CTM_ST_WR;
                    end
                endcase
            end
            CTM_ST_RD: begin
                dat_nxt   = mem_rdata;
                state_nxt = CTM_ST_OP;
                pre_nxt   = 1'b0;
                unique case (op_r)
                    CTM_OP_LOAD_FULL, CTM_OP_LOAD_LONG, CTM_OP_LOAD_SHORT,
                    CTM_OP_LOAD_BARE: begin
                        regs_nxt.a     = mem_rdata;
                        regs_nxt.flags = nz_flags(regs_r.flags, mem_rdata);
                    end
                    CTM_OP_CBEQ_DIR: state_nxt = CTM_ST_REL;
                    CTM_OP_CBEQ_OFSP, CTM_OP_CBEQ_IXP: begin
                        {regs_nxt.h, regs_nxt.x} = hx + CTM_ONE16;
                        state_nxt = CTM_ST_REL;
                    end
                    CTM_OP_MOV_DIXP: begin
                        ea_nxt    = hx;
                        state_nxt = CTM_ST_WR;
                    end
                    CTM_OP_MOV_IXPD: begin
                        {regs_nxt.h, regs_nxt.x} = hx + CTM_ONE16;
                        state_nxt = CTM_ST_B2;
                    end
                    default: regs_nxt.flags = nz_flags(regs_r.flags, mem_rdata);
                endcase
            end
            CTM_ST_WR: begin
                regs_nxt.flags = nz_flags(regs_r.flags, dat_r);
                if (op_r == CTM_OP_MOV_DIXP) begin
                    {regs_nxt.h, regs_nxt.x} = hx + CTM_ONE16;
                end
                state_nxt = CTM_ST_OP;
            end
            CTM_ST_REL: begin
                // Offset counts from the address after the offset byte
                if (regs_r.a == dat_r) begin
                    regs_nxt.pc = regs_r.pc + CTM_ONE16 + {{8{mem_rdata[7]}}, mem_rdata};
                end else begin
                    regs_nxt.pc = regs_r.pc + CTM_ONE16;
                end
                state_nxt = CTM_ST_OP;
            end
            CTM_ST_EXE: begin
                if (op_r == CTM_OP_STACK_TO_IDX) begin
                    {regs_nxt.h, regs_nxt.x} = regs_r.sp + CTM_ONE16;
                end else begin
                    regs_nxt.sp = hx - CTM_ONE16;
                end
                state_nxt = CTM_ST_OP;
            end
            default: state_nxt = CTM_ST_OP;
        endcase

        // Bus request for the cycle the sequencer enters next
        bus_nxt.rd    = 1'b0;
        bus_nxt.wr    = 1'b0;
        bus_nxt.addr  = regs_nxt.pc;
        bus_nxt.wdata = dat_nxt;
        unique case (state_nxt)
            CTM_ST_OP, CTM_ST_B1, CTM_ST_B2, CTM_ST_REL: bus_nxt.rd = 1'b1;
            CTM_ST_RD: begin
                bus_nxt.rd   = 1'b1;
                bus_nxt.addr = ea_nxt;
            end
            CTM_ST_WR: begin
                bus_nxt.wr   = 1'b1;
                bus_nxt.addr = ea_nxt;
            end
            default: bus_nxt.rd = 1'b0;                            // Internal cycle, bus idle
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset leaves an opcode fetch at the start address already on the bus
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= CTM_ST_OP;
            regs_r  <= '{pc: CTM_PC_RESET, sp: CTM_SP_RESET, h: CTM_BYTE_ZERO,
                         x: CTM_BYTE_ZERO, a: CTM_BYTE_ZERO, flags: CTM_FLAGS_RESET};
            bus_r   <= '{addr: CTM_PC_RESET, rd: 1'b1, wr: 1'b0, wdata: CTM_BYTE_ZERO};
            op_r    <= CTM_BYTE_ZERO;
            pre_r   <= 1'b0;
            ea_r    <= '0;
            hi_r    <= CTM_BYTE_ZERO;
            dat_r   <= CTM_BYTE_ZERO;
        end else begin
            state_r <= state_nxt;
            regs_r  <= regs_nxt;
            bus_r   <= bus_nxt;
            op_r    <= op_nxt;
            pre_r   <= pre_nxt;
            ea_r    <= ea_nxt;
            hi_r    <= hi_nxt;
            dat_r   <= dat_nxt;
        end
    end

    assign bus  = bus_r;
    assign regs = regs_r;

endmodule

/* verilog/ctm_pkg.sv */
// Shared constants, opcodes and carrier types for the test and transfer core
package ctm_pkg;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] CTM_PC_RESET   = 16'h0000;  // Plain default start address
    localparam logic [15:0] CTM_SP_RESET   = 16'h00FF;  // Plain default stack top
    localparam logic [7:0]  CTM_FLAGS_RESET = 8'h68;    // Mask set, fixed ones set
    localparam logic [7:0]  CTM_BYTE_ZERO  = 8'h00;
    localparam logic [15:0] CTM_ONE16      = 16'h0001;

    // ------------------------------------------------------------------
    // Condition flag bit positions
    // ------------------------------------------------------------------
    localparam int CTM_FLAG_V = 7;
    localparam int CTM_FLAG_N = 2;
    localparam int CTM_FLAG_Z = 1;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] CTM_OP_PREFIX     = 8'h9E;  // Stack-relative prefix byte
    localparam logic [7:0] CTM_OP_ZTEST_DIR   = 8'h3D;
    localparam logic [7:0] CTM_OP_ZTEST_ACC   = 8'h4D;
    localparam logic [7:0] CTM_OP_ZTEST_IDX   = 8'h5D;
    localparam logic [7:0] CTM_OP_ZTEST_OFS   = 8'h6D;  // Stack short form after prefix
    localparam logic [7:0] CTM_OP_ZTEST_BARE  = 8'h7D;
    localparam logic [7:0] CTM_OP_LOAD_FULL   = 8'hC6;
    localparam logic [7:0] CTM_OP_LOAD_LONG   = 8'hD6;  // Stack long form after prefix
    localparam logic [7:0] CTM_OP_LOAD_SHORT  = 8'hE6;  // Stack short form after prefix
    localparam logic [7:0] CTM_OP_LOAD_BARE   = 8'hF6;
    localparam logic [7:0] CTM_OP_CBEQ_DIR    = 8'h31;
    localparam logic [7:0] CTM_OP_CBEQ_OFSP   = 8'h61;
    localparam logic [7:0] CTM_OP_CBEQ_IXP    = 8'h71;
    localparam logic [7:0] CTM_OP_MOV_DIXP    = 8'h5E;
    localparam logic [7:0] CTM_OP_MOV_IMMDIR  = 8'h6E;
    localparam logic [7:0] CTM_OP_MOV_IXPD    = 8'h7E;
    localparam logic [7:0] CTM_OP_ACC_TO_IDX  = 8'h97;
    localparam logic [7:0] CTM_OP_IDX_TO_ACC  = 8'h9F;
    localparam logic [7:0] CTM_OP_FLAGS_TO_ACC = 8'h85;
    localparam logic [7:0] CTM_OP_STACK_TO_IDX = 8'h95;
    localparam logic [7:0] CTM_OP_IDX_TO_STACK = 8'h94;

    // ------------------------------------------------------------------
    // Sequencer states and carriers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CTM_ST_OP  = 3'b000,  // Opcode fetch
        CTM_ST_B1  = 3'b001,  // First operand byte
        CTM_ST_B2  = 3'b010,  // Second operand byte
        CTM_ST_RD  = 3'b011,  // Data read at effective address
        CTM_ST_WR  = 3'b100,  // Data write at effective address
        CTM_ST_REL = 3'b101,  // Branch offset fetch
        CTM_ST_EXE = 3'b110   // Internal cycle of stack transfers
    } ctm_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } ctm_bus_s;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] sp;
        logic [7:0]  h;
        logic [7:0]  x;
        logic [7:0]  a;
        logic [7:0]  flags;
    } ctm_regs_s;

endpackage
